// File: include/board_regs_pkg.sv
// constants and types for the pipeline host register port
package board_regs_pkg;
  localparam logic [4:0] STATUS_OFS = 5'h00;
  localparam logic [4:0] CONTROL_OFS = 5'h02;
  localparam logic [4:0] LINE_LEN_OFS = 5'h04;
  localparam logic [4:0] PROG_OFS = 5'h06;
  localparam logic [4:0] IMAGE_OFS = 5'h08;
  localparam int CTL_START = 0;
  localparam int CTL_FLUSH = 1;
  localparam int CTL_CLEAR = 2;
  localparam int CTL_SEL_LO = 3;
  localparam int CTL_TSEL_LO = 5;
  localparam int CTL_ALT_LO = 8;
  localparam int ST_CHG = 8;
  localparam int ST_DRV = 9;
  localparam int ST_ROLE = 10;
  localparam int ST_COL = 12;
  localparam int ST_UND = 13;
  localparam int ST_OVR = 14;
  localparam int ST_ERR = 15;
  localparam int LEN_W = 12;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [1:0] TSEL_RST = 2'h0;
  localparam logic [2:0] ALT_RST = 3'h0;
  localparam logic [LEN_W-1:0] LEN_RST = 12'h000;
  localparam logic [LEN_W-1:0] LEN_WRAP = 12'hFFF;
  typedef enum logic [1:0] {IO_WORKSTATION, IO_REGION, IO_DUAL_BYTE, IO_VME} io_sel_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_e;
  typedef enum logic [1:0] {ENG_IDLE, ENG_PUSH, ENG_POP} eng_e;
  typedef struct packed {
    logic line_start_marker_n;
    logic command_marker_n;
    logic pixel_valid_n;
    logic [7:0] data;
  } pix_s;
  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    size_e size;
    logic [31:0] wdata;
  } bus_req_s;
endpackage

// File: rtl/pipeline_host_register_port.sv
// host register port, line buffer and line-marker generation for the stage pipeline
`timescale 1ns/1ps

module line_buffer_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  import board_regs_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;
  fifo_s q;
  fifo_s nxt;
  logic push;
  logic pop;

  assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rp];

  // depth must be a power of two so the pointers wrap by themselves
  always_comb
  begin
    nxt = q;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    if (push)
    begin
      nxt.mem[q.wp] = in_data_i;
      nxt.wp = q.wp + 1'b1;
    end
    if (pop)
      nxt.rp = q.rp + 1'b1;
    nxt.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (clear_i)
    begin
      nxt.wp = '0;
      nxt.rp = '0;
      nxt.cnt = '0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= nxt;
  end
endmodule

module pipeline_host_register_port #(
  parameter logic [7:0] BOARD_ID = 8'hA4, // arbitrary value
  parameter int DEPTH = board_regs_pkg::FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic bus_strobe_i,
  input wire board_regs_pkg::bus_req_s bus_req_i,
  output logic bus_ready_o,
  output logic bus_ack_o,
  output logic [31:0] bus_rdata_o,
  output logic pipe_adv_o,
  output board_regs_pkg::pix_s pipe_in_o,
  input wire board_regs_pkg::pix_s pipe_end_i,
  input wire logic pipe_out_valid_i,
  input wire logic [7:0] pipe_out_data_i,
  output logic pipe_out_ready_o,
  input wire logic image_changed_signal_i,
  input wire logic hs_xfer_active_i,
  input wire logic output_driver_enable_sense_i,
  input wire logic output_role_sense_i,
  input wire logic backplane_detect_i,
  output board_regs_pkg::io_sel_e io_sel_o,
  output logic [1:0] timing_sel_o,
  output logic [2:0] driver_alt_o,
  output logic backplane_en_o
);
  import board_regs_pkg::*;

  typedef struct packed {
    eng_e st;
    logic [2:0] n;
    logic [31:0] sh;
    logic [31:0] rdata;
    logic ack;
    logic adv;
    pix_s pix;
    io_sel_e sel;
    logic [1:0] tsel;
    logic [2:0] alt;
    logic flush;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] cnt;
    logic first;
    logic ovr;
    logic und;
    logic col;
    logic chg;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] flt;
  } state_s;

  state_s q;
  state_s nxt;
  logic fifo_clear;
  logic fifo_pop;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [15:0] wd;
  logic [15:0] status;
  logic vme;
  logic take;

  function automatic logic [2:0] pixels(input size_e sz);
    case (sz)
      SZ_LONG: pixels = 3'd4;
      SZ_WORD: pixels = 3'd2;
      default: pixels = 3'd1;
    endcase
  endfunction

  // one pixel step of the line counter: {first, cnt} after the pixel
  function automatic logic [LEN_W:0] line_step(input logic [LEN_W-1:0] cnt, input logic [LEN_W-1:0] len);
    if (cnt == LEN_WRAP)
      line_step = {1'b1, len};
    else
      line_step = {1'b0, cnt + 1'b1};
  endfunction

  line_buffer_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(fifo_clear),
    .in_valid_i(pipe_out_valid_i),
    .in_data_i(pipe_out_data_i),
    .in_ready_o(pipe_out_ready_o),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  assign vme = (q.sel == IO_VME);
  assign take = bus_strobe_i && (q.st == ENG_IDLE);
  assign wd = bus_req_i.wdata[15:0];
  assign bus_ready_o = (q.st == ENG_IDLE);
  assign bus_ack_o = q.ack;
  assign bus_rdata_o = q.rdata;
  assign pipe_adv_o = q.adv;
  assign pipe_in_o = q.pix;
  assign io_sel_o = q.sel;
  assign timing_sel_o = q.tsel;
  assign driver_alt_o = q.alt;
  assign backplane_en_o = q.flt[2];

  always_comb
  begin
    status = '0;
    status[7:0] = BOARD_ID;
    status[ST_CHG] = q.chg;
    status[ST_DRV] = q.flt[0];
    status[ST_ROLE] = q.flt[1];
    status[ST_COL] = q.col;
    status[ST_UND] = q.und;
    status[ST_OVR] = q.ovr;
    status[ST_ERR] = q.ovr || q.und || q.col;
  end

  always_comb
  begin
    nxt = q;
    nxt.ack = 1'b0;
    nxt.adv = 1'b0;
    fifo_clear = 1'b0;
    fifo_pop = 1'b0;
    // three-stage sensing; a level counts once stages two and three agree
    nxt.s1 = {backplane_detect_i, output_role_sense_i, output_driver_enable_sense_i};
    nxt.s2 = q.s1;
    nxt.s3 = q.s2;
    nxt.flt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.flt);
    unique case (q.st)
      ENG_IDLE:
      begin
        if (take)
        begin
          nxt.ack = 1'b1;
          nxt.rdata = '0;
          if (bus_req_i.addr == CONTROL_OFS && bus_req_i.wr)
          begin
            if (wd[CTL_CLEAR])
            begin
              nxt.ovr = 1'b0;
              nxt.und = 1'b0;
              nxt.col = 1'b0;
            end
            if (wd[CTL_START])
            begin
              fifo_clear = 1'b1;
              nxt.chg = 1'b0;
              nxt.cnt = q.len;
              nxt.first = 1'b1;
            end
            nxt.flush = wd[CTL_FLUSH];
            nxt.sel = io_sel_e'(wd[CTL_SEL_LO +: 2]);
            nxt.tsel = wd[CTL_TSEL_LO +: 2];
            nxt.alt = wd[CTL_ALT_LO +: 3];
            // set after the clear so a collision in the clearing write survives
            if (nxt.sel != q.sel && hs_xfer_active_i)
              nxt.col = 1'b1;
          end
          else if (bus_req_i.addr == CONTROL_OFS)
          begin
            nxt.rdata[15:0] = {5'h00, q.alt, 1'b0, q.tsel, q.sel, 3'h0};
          end
          else if (bus_req_i.addr == LINE_LEN_OFS)
          begin
            if (bus_req_i.wr)
              nxt.len = wd[LEN_W-1:0];
            else
              nxt.rdata[LEN_W-1:0] = q.len;
          end
          else if (bus_req_i.addr == PROG_OFS)
          begin
            // access outside the bus interface code is ignored
            if (bus_req_i.wr && vme)
            begin
              nxt.adv = 1'b1;
              nxt.pix = pix_s'(wd[10:0]);
            end
            else if (!bus_req_i.wr && vme)
              nxt.rdata[10:0] = pipe_end_i;
          end
          else if (bus_req_i.addr[4:2] == IMAGE_OFS[4:2] && vme)
          begin
            nxt.ack = 1'b0;
            nxt.n = pixels(bus_req_i.size);
            nxt.st = bus_req_i.wr ? ENG_PUSH : ENG_POP;
            case (bus_req_i.size)
              SZ_LONG: nxt.sh = bus_req_i.wdata;
              SZ_WORD: nxt.sh = {wd, 16'h0000};
              default: nxt.sh = {bus_req_i.wdata[7:0], 24'h000000};
            endcase
          end
          else if (bus_req_i.addr == STATUS_OFS && !bus_req_i.wr)
          begin
            nxt.rdata[15:0] = status;
          end
        end
        else if (q.flush && vme && pipe_out_ready_o)
        begin
          // null pixels keep line timing; stalls while the buffer is full
          nxt.adv = 1'b1;
          nxt.pix = '{line_start_marker_n: ~q.first, command_marker_n: 1'b1, pixel_valid_n: 1'b1, data: 8'h00};
          {nxt.first, nxt.cnt} = line_step(q.cnt, q.len);
        end
      end
      ENG_PUSH:
      begin
        nxt.adv = 1'b1;
        nxt.pix = '{line_start_marker_n: ~q.first, command_marker_n: 1'b1, pixel_valid_n: 1'b0, data: q.sh[31:24]};
        {nxt.first, nxt.cnt} = line_step(q.cnt, q.len);
        nxt.sh = {q.sh[23:0], 8'h00};
        nxt.n = q.n - 3'd1;
        if (q.n == 3'd1)
        begin
          nxt.st = ENG_IDLE;
          nxt.ack = 1'b1;
        end
      end
      ENG_POP:
      begin
        fifo_pop = 1'b1;
        nxt.rdata = {q.rdata[23:0], fifo_valid ? fifo_data : 8'h00};
        if (!fifo_valid)
          nxt.und = 1'b1;
        nxt.n = q.n - 3'd1;
        if (q.n == 3'd1)
        begin
          nxt.st = ENG_IDLE;
          nxt.ack = 1'b1;
        end
      end
    endcase
    // hardware events last, so a set beats a clear in the same cycle
    if (pipe_out_valid_i && !pipe_out_ready_o)
      nxt.ovr = 1'b1;
    if (image_changed_signal_i)
      nxt.chg = 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.sel <= io_sel_e'(SEL_RST);
      q.tsel <= TSEL_RST;
      q.alt <= ALT_RST;
      q.len <= LEN_RST;
      q.flush <= 1'b0;
    end
    else
      q <= nxt;
  end

  property p_overrun;
    @(posedge mclk_i) disable iff (rst_i) pipe_out_valid_i && !pipe_out_ready_o |=> q.ovr && status[ST_ERR];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_underrun;
    @(posedge mclk_i) disable iff (rst_i) q.st == ENG_POP && !fifo_valid |=> q.und;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");

  property p_summary;
    @(posedge mclk_i) disable iff (rst_i) status[ST_ERR] == (status[ST_OVR] | status[ST_UND] | status[ST_COL]);
  endproperty
  a_summary: assert property (p_summary) else $error("summary error bit wrong");

  property p_collision;
    @(posedge mclk_i) disable iff (rst_i)
      take && bus_req_i.wr && bus_req_i.addr == CONTROL_OFS && hs_xfer_active_i
      && bus_req_i.wdata[4:3] != q.sel |=> q.col;
  endproperty
  a_collision: assert property (p_collision) else $error("collision not flagged");

  property p_clear;
    @(posedge mclk_i) disable iff (rst_i)
      take && bus_req_i.wr && bus_req_i.addr == CONTROL_OFS && bus_req_i.wdata[CTL_CLEAR] && !hs_xfer_active_i
      |=> !q.col;
  endproperty
  a_clear: assert property (p_clear) else $error("clear errors ignored");

  property p_reset;
    @(posedge mclk_i) rst_i |=> q.sel == IO_WORKSTATION && !q.flush && q.alt == 3'h0 && q.tsel == 2'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");

  property p_prog_read;
    @(posedge mclk_i) disable iff (rst_i)
      take && !bus_req_i.wr && bus_req_i.addr == PROG_OFS && !q.flush |=> !pipe_adv_o ##1 bus_rdata_o == $past(bus_rdata_o);
  endproperty
  a_prog_read: assert property (p_prog_read) else $error("read advanced pipeline");

  property p_long_write;
    @(posedge mclk_i) disable iff (rst_i)
      take && vme && bus_req_i.wr && bus_req_i.addr[4:2] == 3'b010 && bus_req_i.size == SZ_LONG
      |-> ##2 pipe_adv_o[*4] ##0 bus_ack_o;
  endproperty
  a_long_write: assert property (p_long_write) else $error("long write not four pixels");

  property p_start;
    @(posedge mclk_i) disable iff (rst_i)
      take && bus_req_i.wr && bus_req_i.addr == CONTROL_OFS && bus_req_i.wdata[CTL_START]
      |=> q.first && q.cnt == q.len && !fifo_valid;
  endproperty
  a_start: assert property (p_start) else $error("image start incomplete");

  property p_flush;
    @(posedge mclk_i) disable iff (rst_i)
      q.st == ENG_IDLE && !bus_strobe_i && q.flush && vme && pipe_out_ready_o
      |=> pipe_adv_o && pipe_in_o.pixel_valid_n && pipe_in_o.command_marker_n;
  endproperty
  a_flush: assert property (p_flush) else $error("flush pixel missing");

  property p_line_wrap;
    @(posedge mclk_i) disable iff (rst_i) q.st == ENG_PUSH && q.cnt == LEN_WRAP |=> q.first && q.cnt == $past(q.len);
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("line marker counter wrap wrong");
endmodule

// File: tb/stage_pipe_model.sv
// behavioural stage pipeline standing at the far side of the register port
`timescale 1ns/1ps

module stage_pipe_model
  import board_regs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic pipe_adv_i,
  input wire board_regs_pkg::pix_s pipe_in_i,
  output board_regs_pkg::pix_s pipe_end_o,
  output logic out_valid_o,
  output logic [7:0] out_data_o
);
  // one stage deep; the real chain is longer but only the order matters here
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pipe_end_o <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= 8'hFF;
    end
    else
    begin
      if (pipe_adv_i)
        pipe_end_o <= pipe_in_i;
      // cannot stall: a pixel offered to a full buffer is simply lost
      out_valid_o <= pipe_adv_i && !pipe_in_i.pixel_valid_n;
      // data line shows garbage between pixels
      out_data_o <= (pipe_adv_i && !pipe_in_i.pixel_valid_n) ? pipe_in_i.data : ~out_data_o;
    end
  end
endmodule

// File: tb/test_pipeline_host_register_port.sv
// self-checking testbench for the pipeline host register port
`timescale 1ns/1ps

module test_pipeline_host_register_port;
  import board_regs_pkg::*;
  localparam logic [7:0] ID = 8'h3C; // arbitrary value
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strobe = 1'b0;
  bus_req_s req = '0;
  logic ready, ack, adv, oready, ov, bpen;
  logic [31:0] rdata;
  pix_s pin, pend;
  logic [7:0] od;
  logic chg = 1'b0;
  logic hs = 1'b0;
  logic drv_sense = 1'b1;
  logic role_sense = 1'b1;
  logic bp = 1'b0;
  io_sel_e iosel;
  logic [1:0] tsel;
  logic [2:0] alt;
  int n_fail = 0;
  int checks = 0;
  int n_adv = 0;
  int n0, mk;
  pix_s q[$];
  logic [31:0] r;

  always #4 mclk_i = ~mclk_i;

  pipeline_host_register_port #(.BOARD_ID(ID), .DEPTH(FIFO_DEPTH)) uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .bus_strobe_i(strobe), .bus_req_i(req), .bus_ready_o(ready),
    .bus_ack_o(ack), .bus_rdata_o(rdata), .pipe_adv_o(adv), .pipe_in_o(pin), .pipe_end_i(pend),
    .pipe_out_valid_i(ov), .pipe_out_data_i(od), .pipe_out_ready_o(oready), .image_changed_signal_i(chg),
    .hs_xfer_active_i(hs), .output_driver_enable_sense_i(drv_sense), .output_role_sense_i(role_sense),
    .backplane_detect_i(bp), .io_sel_o(iosel), .timing_sel_o(tsel), .driver_alt_o(alt), .backplane_en_o(bpen));

  stage_pipe_model pipe (.mclk_i(mclk_i), .rst_i(rst_i), .pipe_adv_i(adv), .pipe_in_i(pin),
    .pipe_end_o(pend), .out_valid_o(ov), .out_data_o(od));

  // every pipeline step seen at the port
  always @(posedge mclk_i)
  begin
    if (adv === 1'b1)
    begin
      n_adv <= n_adv + 1;
      q.push_back(pin);
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until the take edge, answer taken in the ack cycle
  task automatic bus(input logic w, input logic [4:0] a, input size_e sz, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    strobe <= 1'b1;
    req <= '{wr: w, addr: a, size: sz, wdata: d};
    @(posedge mclk_i);
    strobe <= 1'b0;
    k = 0;
    do
    begin
      @(posedge mclk_i);
      k++;
      chk("bus ready", ack === 1'b1, ready);
    end
    while (ack !== 1'b1 && k < 50);
    if (k >= 50)
      chk("bus ack", 1, 0);
    r = rdata;
  endtask

  function automatic logic [31:0] st(input logic [3:0] e, input logic c);
    return {16'h0, e, 1'b0, role_sense, drv_sense, c, ID};
  endfunction

  task automatic fin(input string nm);
    $display("end of test %s", nm);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    // sense levels need the filter to settle first
    repeat (4) @(posedge mclk_i);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("status", st(4'h0, 0), r);
    bus(0, CONTROL_OFS, SZ_WORD, 0);
    chk("control", 0, r);
    chk("io_sel", 0, iosel);
    bus(0, LINE_LEN_OFS, SZ_WORD, 0);
    chk("line len", 0, r);
    bus(1, STATUS_OFS, SZ_WORD, 32'hFFFF);
    bus(0, 5'h0C, SZ_WORD, 0);
    chk("unmapped", 0, r);
    fin("reset");
    for (int i = 0; i < 4; i++)
    begin
      bus(1, CONTROL_OFS, SZ_WORD, (i << 3) | ((3 - i) << 5) | ((7 - i) << 8));
      bus(0, CONTROL_OFS, SZ_WORD, 0);
      chk("control rb", (i << 3) | ((3 - i) << 5) | ((7 - i) << 8), r);
      chk("io_sel", i, iosel);
      chk("timing_sel", 3 - i, tsel);
      chk("driver_alt", 7 - i, alt);
    end
    fin("control");
    @(posedge mclk_i);
    role_sense <= 1'b0;
    bp <= 1'b1;
    repeat (8) @(posedge mclk_i);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("sense", st(4'h0, 0), r);
    chk("backplane", 1, bpen);
    fin("sense");
    bus(1, CONTROL_OFS, SZ_WORD, 32'h0);
    n0 = n_adv;
    bus(1, PROG_OFS, SZ_WORD, 32'h0500);
    bus(0, PROG_OFS, SZ_WORD, 0);
    chk("prog off", 0, r);
    chk("adv off", n0, n_adv);
    bus(1, CONTROL_OFS, SZ_WORD, 32'h18);
    bus(1, PROG_OFS, SZ_WORD, 32'h0500);
    @(negedge mclk_i);
    chk("prog in", 11'h500, q[$]);
    n0 = n_adv;
    bus(0, PROG_OFS, SZ_WORD, 0);
    chk("prog rd1", 32'h500, r);
    bus(0, PROG_OFS, SZ_WORD, 0);
    chk("prog rd2", 32'h500, r);
    chk("reads no adv", n0, n_adv);
    fin("programming");
    bus(1, LINE_LEN_OFS, SZ_WORD, 32'hFFC);
    bus(0, LINE_LEN_OFS, SZ_WORD, 0);
    chk("line len", 32'hFFC, r);
    bus(1, CONTROL_OFS, SZ_WORD, 32'h19);
    q.delete();
    bus(1, IMAGE_OFS, SZ_LONG, 32'h11223344);
    bus(1, 5'h0A, SZ_WORD, 32'h5566);
    @(negedge mclk_i);
    for (int i = 0; i < 6; i++)
      chk("pixel", {i % 4 != 0, 2'b10, 8'(48'h11223344_5566 >> (8 * (5 - i)))}, q[i]);
    repeat (3) @(posedge mclk_i);
    bus(0, IMAGE_OFS, SZ_LONG, 0);
    chk("img long", 32'h11223344, r);
    bus(0, IMAGE_OFS, SZ_WORD, 0);
    chk("img word", 32'h5566, r);
    bus(0, 5'h0B, SZ_BYTE, 0);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("underrun", st(4'hA, 0), r);
    bus(1, CONTROL_OFS, SZ_WORD, 32'h1C);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("cleared", st(4'h0, 0), r);
    fin("image");
    bus(1, IMAGE_OFS, SZ_LONG, 32'hAABBCCDD);
    bus(1, IMAGE_OFS, SZ_LONG, 32'h01020304);
    bus(1, 5'h09, SZ_BYTE, 32'h77);
    repeat (3) @(posedge mclk_i);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("overrun", st(4'hC, 0), r);
    chk("buffer full", 0, oready);
    bus(0, IMAGE_OFS, SZ_LONG, 0);
    chk("full 1", 32'hAABBCCDD, r);
    bus(0, 5'h0A, SZ_LONG, 0);
    chk("full 2", 32'h01020304, r);
    bus(1, CONTROL_OFS, SZ_WORD, 32'h1C);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("cleared", st(4'h0, 0), r);
    fin("overrun");
    bus(1, CONTROL_OFS, SZ_WORD, 32'h1A);
    q.delete();
    for (int k = 0; k < 50 && q.size() < 8; k++)
      @(posedge mclk_i);
    mk = 0;
    for (int i = 0; i < 8; i++)
      mk += (q[i].line_start_marker_n === 1'b0);
    chk("null markers", 2, mk);
    chk("null pixel", 10'h300, q[0][9:0]);
    bus(1, CONTROL_OFS, SZ_WORD, 32'h18);
    repeat (3) @(posedge mclk_i);
    n0 = n_adv;
    repeat (10) @(posedge mclk_i);
    chk("flush off", n0, n_adv);
    fin("flush");
    hs <= 1'b1;
    bus(1, CONTROL_OFS, SZ_WORD, 32'h0);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("collision", st(4'h9, 0), r);
    bus(1, CONTROL_OFS, SZ_WORD, 32'h04);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("col clear", st(4'h0, 0), r);
    hs <= 1'b0;
    bus(1, CONTROL_OFS, SZ_WORD, 32'h18);
    bus(1, IMAGE_OFS, SZ_BYTE, 32'hAB);
    chg <= 1'b1;
    @(posedge mclk_i);
    chg <= 1'b0;
    repeat (3) @(posedge mclk_i);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("changed", st(4'h0, 1), r);
    bus(1, CONTROL_OFS, SZ_WORD, 32'h19);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("start clr", st(4'h0, 0), r);
    bus(0, IMAGE_OFS, SZ_BYTE, 0);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("emptied", st(4'hA, 0), r);
    fin("status");
    bus(1, CONTROL_OFS, SZ_WORD, 32'h1A);
    hs <= 1'b1;
    bus(1, CONTROL_OFS, SZ_WORD, 32'h02);
    bus(1, CONTROL_OFS, SZ_WORD, 32'h1A);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    hs <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk("io_sel rst", 0, iosel);
    bus(0, STATUS_OFS, SZ_WORD, 0);
    chk("status rst", st(4'h0, 0), r);
    bus(1, CONTROL_OFS, SZ_WORD, 32'h18);
    n0 = n_adv;
    repeat (10) @(posedge mclk_i);
    chk("flush rst", n0, n_adv);
    fin("second reset");
    wrap_up();
  end
endmodule
